// *** sim/mma_rf_model.sv ***
`timescale 1ns/1ps
module mma_rf_model
	import mma_pkg::*;
(
	// clock
	input  wire logic              clk,
	// request to the alu
	output logic                   op_valid,
	output mma_op_t                op_sel,
	output logic      [DATA_W-1:0] d_in,
	output logic      [DATA_W-1:0] s_in,
	output logic                   write_carry,
	output logic                   write_zero
);
	initial begin
		op_valid = 1'b0;
		op_sel = OP_COPY;
		d_in = '0;
		s_in = '0;
		write_carry = 1'b0;
		write_zero = 1'b0;
	end
	task automatic issue(input mma_op_t o, input logic [DATA_W-1:0] d, s,
			input logic wc, wz);
		@(posedge clk);
		op_valid <= 1'b1;
		op_sel <= o;
		d_in <= d;
		s_in <= s;
		write_carry <= wc;
		write_zero <= wz;
	endtask
	// released operands flip so stale data cannot pass for good
	task automatic idle();
		@(posedge clk);
		op_valid <= 1'b0;
		d_in <= ~d_in;
		s_in <= ~s_in;
	endtask
endmodule

// *** sim/tb_mma_alu.sv ***
`timescale 1ns/1ps
module tb_mma_alu;
	import mma_pkg::*;
	logic              clk;
	logic              rst;
	logic              op_valid;
	mma_op_t           op_sel;
	logic [DATA_W-1:0] d_in;
	logic [DATA_W-1:0] s_in;
	logic              write_carry;
	logic              write_zero;
	logic [DATA_W-1:0] result_q;
	logic              result_valid_q;
	logic              carry_q;
	logic              zero_q;
	int                failures;
	int                n_compared;
	mma_alu mma_alu_inst (.clk(clk), .rst(rst), .op_valid(op_valid),
		.op_sel(op_sel), .d_in(d_in), .s_in(s_in),
		.write_carry(write_carry), .write_zero(write_zero),
		.result_q(result_q), .result_valid_q(result_valid_q),
		.carry_q(carry_q), .zero_q(zero_q));
	mma_rf_model mma_rf_model_inst (.clk(clk), .op_valid(op_valid),
		.op_sel(op_sel), .d_in(d_in), .s_in(s_in),
		.write_carry(write_carry), .write_zero(write_zero));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic check(input logic [DATA_W-1:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic flags(input logic c, z);
		check(carry_q, c);
		check(zero_q, z);
	endtask
	task automatic do_op(input mma_op_t o, input logic [DATA_W-1:0] d, s,
			input logic wc, wz);
		mma_rf_model_inst.issue(o, d, s, wc, wz);
		mma_rf_model_inst.idle();
		#1;
		check(result_valid_q, 1'b1);
	endtask
	task automatic t_copy();
		do_op(OP_COPY, 32'h1234_5678, 32'h8000_0001, 1'b1, 1'b1);
		check(result_q, 32'h8000_0001);
		flags(1'b1, 1'b0);
		do_op(OP_COPY, 32'hffff_ffff, 32'h0000_0000, 1'b0, 1'b1);
		flags(1'b1, 1'b1);
		do_op(OP_COPY, 32'h0000_0000, 32'h7fff_ffff, 1'b0, 1'b0);
		check(result_q, 32'h7fff_ffff);
		flags(1'b1, 1'b1);
	endtask
	task automatic t_shuffle();
		do_op(OP_BYTE_SHUF, 32'h4433_2211, 32'h0000_001b, 1'b1, 1'b1);
		check(result_q, 32'h1122_3344);
		flags(1'b1, 1'b1);
		do_op(OP_BYTE_SHUF, 32'h4433_2211, 32'hffff_ff06, 1'b0, 1'b0);
		check(result_q, 32'h1111_2233);
	endtask
	task automatic t_mul();
		do_op(OP_UMUL, 32'h1234_ffff, 32'hffff_ffff, 1'b0, 1'b1);
		check(result_q, 32'hfffe_0001);
		check(zero_q, 1'b0);
		do_op(OP_SMUL, 32'h1234_ffff, 32'hffff_ffff, 1'b0, 1'b1);
		check(result_q, 32'h0000_0001);
		do_op(OP_SMUL, 32'h0000_7fff, 32'h0000_8000, 1'b0, 1'b1);
		check(result_q, 32'hc000_8000);
		flags(1'b1, 1'b0);
		do_op(OP_UMUL, 32'h0000_0000, 32'h0000_0005, 1'b1, 1'b1);
		check(result_q, 32'h0000_0000);
		flags(1'b1, 1'b1);
	endtask
	task automatic t_mux();
		mma_rf_model_inst.issue(OP_CARRY_MUX, 32'h0, 32'h3, 1'b1, 1'b0);
		mma_rf_model_inst.issue(OP_INV_CARRY, 32'hf0, 32'h3, 1'b1, 1'b1);
		mma_rf_model_inst.idle();
		#1;
		check(result_q, 32'h0000_00f3);
		flags(1'b0, 1'b0);
		do_op(OP_CARRY_MUX, 32'h0000_ff00, 32'h0f0f_0f0f, 1'b1, 1'b1);
		check(result_q, 32'h0000_f000);
		do_op(OP_INV_CARRY, 32'h0, 32'h1, 1'b1, 1'b0);
		check(carry_q, 1'b1);
		do_op(OP_CARRY_MUX, 32'h0, 32'h8000_0000, 1'b0, 1'b1);
		check(result_q, 32'h8000_0000);
		check(carry_q, 1'b1);
	endtask
	task automatic t_fields();
		do_op(OP_PAIR_COPY, 32'hffff_ffff, 32'h0000_0024, 1'b0, 1'b1);
		check(result_q, 32'hffff_ffe7);
		flags(1'b1, 1'b0);
		do_op(OP_NIBBLE_COPY, 32'hffff_ffff, 32'h00a0_0005, 1'b0, 1'b0);
		check(result_q, 32'hffaf_fff5);
		do_op(OP_NIBBLE_COPY, 32'h1234_5678, 32'hf000_0000, 1'b0, 1'b0);
		check(result_q, 32'hf234_5678);
		do_op(mma_op_t'(8'h03), 32'hcafe_0001, 32'h0000_0001, 1'b1, 1'b1);
		check(result_q, 32'hcafe_0001);
		flags(1'b1, 1'b0);
		@(posedge clk);
		#1;
		check(result_valid_q, 1'b0);
	endtask
	task automatic print_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		failures++;
		print_verdict();
	end
	initial begin
		failures = 0;
		n_compared = 0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check(result_q, 32'h0);
		flags(1'b0, 1'b0);
		t_copy();
		t_shuffle();
		t_mul();
		t_mux();
		t_fields();
		print_verdict();
	end
endmodule

// *** src/mma_alu.sv ***
`timescale 1ns/1ps
// Overview of operation
// - copy writes source to result; carry takes source bit 31
// - shuffle: result bytes are dst bytes indexed by source 2-bit fields
// - unsigned multiply of low halves; zero flag when either operand zero
// - signed multiply of low halves; zero flag as unsigned multiply
// - carry mux loads carry into dst bits under one mask bits
// - mux family carry update takes parity of the result
// - nonzero source bit pairs overwrite dst pairs, zero pairs keep dst
// - inverted carry mux loads not carry under mask; carry may take parity
// - nonzero source nibbles overwrite dst nibbles, zero nibbles keep dst
module mma_alu
	import mma_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// operation request
	input  wire logic              op_valid,
	input  wire mma_op_t           op_sel,
	input  wire logic [DATA_W-1:0] d_in,
	input  wire logic [DATA_W-1:0] s_in,
	input  wire logic              write_carry,
	input  wire logic              write_zero,
	// result and flags
	output logic      [DATA_W-1:0] result_q,
	output logic                   result_valid_q,
	output logic                   carry_q,
	output logic                   zero_q
);

	logic        [DATA_W-1:0] result_d;
	logic        [DATA_W-1:0] pair_res;
	logic        [DATA_W-1:0] nib_res;
	logic        [DATA_W-1:0] shuf_res;
	logic        [DATA_W-1:0] umul_res;
	logic signed [DATA_W-1:0] smul_res;
	logic signed [DATA_W-1:0] smul_d;
	logic signed [DATA_W-1:0] smul_s;
	logic                     carry_calc;
	logic                     carry_ok;
	logic                     zero_calc;
	logic                     zero_ok;
	logic                     ops_zero;

	mma_field_copy #(.W(DATA_W), .F(PAIR_W)) u_pair (
		.src (s_in),
		.dst (d_in),
		.res (pair_res)
	);

	mma_field_copy #(.W(DATA_W), .F(NIB_W)) u_nibble (
		.src (s_in),
		.dst (d_in),
		.res (nib_res)
	);

	// byte index shifted up by three gives the bit offset
	assign shuf_res = {
		d_in[{s_in[SEL3_POS +: SEL_W], 3'h0} +: BYTE_W],
		d_in[{s_in[SEL2_POS +: SEL_W], 3'h0} +: BYTE_W],
		d_in[{s_in[SEL1_POS +: SEL_W], 3'h0} +: BYTE_W],
		d_in[{s_in[SEL0_POS +: SEL_W], 3'h0} +: BYTE_W]
	};

	assign umul_res = {{(DATA_W-MUL_W){1'b0}}, d_in[MUL_W-1:0]} *
	                  {{(DATA_W-MUL_W){1'b0}}, s_in[MUL_W-1:0]};
	// sign extended first so the product is formed at full width
	assign smul_d   = {{(DATA_W-MUL_W){d_in[MUL_W-1]}}, d_in[MUL_W-1:0]};
	assign smul_s   = {{(DATA_W-MUL_W){s_in[MUL_W-1]}}, s_in[MUL_W-1:0]};
	assign smul_res = smul_d * smul_s;
	// whole operands tested, not just the multiplied halves
	assign ops_zero = (s_in == '0) || (d_in == '0);

	always_comb begin
		result_d   = d_in;
		carry_calc = carry_q;
		carry_ok   = 1'b0;
		zero_calc  = zero_q;
		zero_ok    = 1'b0;
		unique case (op_sel)
			OP_COPY: begin
				result_d   = s_in;
				carry_calc = s_in[MSB_POS];
				carry_ok   = 1'b1;
				zero_calc  = (s_in == '0);
				zero_ok    = 1'b1;
			end
			OP_BYTE_SHUF: begin
				result_d = shuf_res;
			end
			OP_UMUL: begin
				result_d  = umul_res;
				zero_calc = ops_zero;
				zero_ok   = 1'b1;
			end
			OP_SMUL: begin
				result_d  = smul_res;
				zero_calc = ops_zero;
				zero_ok   = 1'b1;
			end
			OP_CARRY_MUX: begin
				result_d   = (~s_in & d_in) | (s_in & {DATA_W{carry_q}});
				carry_calc = ^result_d;
				carry_ok   = 1'b1;
				zero_calc  = (result_d == '0);
				zero_ok    = 1'b1;
			end
			OP_INV_CARRY: begin
				result_d   = (~s_in & d_in) | (s_in & {DATA_W{~carry_q}});
				carry_calc = ^result_d;
				carry_ok   = 1'b1;
				zero_calc  = (result_d == '0);
				zero_ok    = 1'b1;
			end
			OP_PAIR_COPY: begin
				result_d = pair_res;
			end
			OP_NIBBLE_COPY: begin
				result_d = nib_res;
			end
			default: begin
				// illegal select passes dst through, flags untouched
				result_d = d_in;
			end
		endcase
	end

	// result register, one cycle after the request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_q <= RESULT_RST;
		end else if (op_valid) begin
			result_q <= result_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_valid_q <= 1'b0;
		end else begin
			result_valid_q <= op_valid;
		end
	end

	// flags held here so back-to-back mux ops see the latest carry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			carry_q <= CARRY_RST;
		end else if (op_valid && write_carry && carry_ok) begin
			carry_q <= carry_calc;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zero_q <= ZERO_RST;
		end else if (op_valid && write_zero && zero_ok) begin
			zero_q <= zero_calc;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_copy_result: assert property (
		op_valid && op_sel == OP_COPY |=> result_q == $past(s_in))
		else $error("copy result differs from source");

	a_copy_carry: assert property (
		op_valid && op_sel == OP_COPY && write_carry
		|=> carry_q == $past(s_in[MSB_POS]))
		else $error("copy carry not source msb");

	a_shuffle_top: assert property (
		op_valid && op_sel == OP_BYTE_SHUF && s_in[7:6] == 2'h0
		|=> result_q[31:24] == $past(d_in[7:0]))
		else $error("shuffle top byte wrong");

	a_umul_value: assert property (
		op_valid && op_sel == OP_UMUL
		|=> result_q == $past(d_in[15:0]) * $past(s_in[15:0]))
		else $error("unsigned product wrong");

	a_mul_zero: assert property (
		op_valid && (op_sel == OP_UMUL || op_sel == OP_SMUL) && write_zero
		|=> zero_q == ($past(s_in) == '0 || $past(d_in) == '0))
		else $error("multiply zero flag wrong");

	a_smul_value: assert property (
		op_valid && op_sel == OP_SMUL
		|=> $signed(result_q) == $signed($past(d_in[15:0]))
		                         * $signed($past(s_in[15:0])))
		else $error("signed product wrong");

	a_cmux_mask: assert property (
		op_valid && op_sel == OP_CARRY_MUX
		|=> result_q == ((~$past(s_in) & $past(d_in))
		                 | ($past(s_in) & {DATA_W{$past(carry_q)}})))
		else $error("carry mux result wrong");

	a_mux_parity: assert property (
		op_valid && write_carry
		&& (op_sel == OP_CARRY_MUX || op_sel == OP_INV_CARRY)
		|=> carry_q == ^result_q)
		else $error("mux carry not result parity");

	a_pair_keep: assert property (
		op_valid && op_sel == OP_PAIR_COPY && s_in[1:0] == 2'h0
		|=> result_q[1:0] == $past(d_in[1:0]))
		else $error("zero pair did not keep dst");

	a_inv_mask: assert property (
		op_valid && op_sel == OP_INV_CARRY && s_in[0]
		|=> result_q[0] == ~$past(carry_q))
		else $error("inverted carry mux bit wrong");

	a_nib_copy: assert property (
		op_valid && op_sel == OP_NIBBLE_COPY && s_in[3:0] != 4'h0
		|=> result_q[3:0] == $past(s_in[3:0]))
		else $error("nonzero nibble not copied");

	a_flags_hold: assert property (
		!(op_valid && (write_carry || write_zero))
		|=> $stable(carry_q) && $stable(zero_q))
		else $error("flags changed without suffix");

	c_copy_wc: cover property (op_valid && op_sel == OP_COPY && write_carry);
	c_smul_wz: cover property (op_valid && op_sel == OP_SMUL && write_zero);
	c_mux_chain: cover property (
		op_valid && op_sel == OP_CARRY_MUX && write_carry
		##1 op_valid && op_sel == OP_INV_CARRY);
	c_nib_copy: cover property (op_valid && op_sel == OP_NIBBLE_COPY);

endmodule

// *** src/mma_field_copy.sv ***
`timescale 1ns/1ps
module mma_field_copy #(
	parameter int W = 32,
	parameter int F = 2
) (
	// operands
	input  wire logic [W-1:0] src,
	input  wire logic [W-1:0] dst,
	// merged word
	output logic      [W-1:0] res
);

	genvar g;
	generate
		for (g = 0; g < W / F; g++) begin : g_field
			// zero field in src keeps dst field
			assign res[g*F +: F] = (|src[g*F +: F]) ? src[g*F +: F]
			                                         : dst[g*F +: F];
		end
	endgenerate

endmodule

// *** src/mma_pkg.sv ***
package mma_pkg;

	localparam int DATA_W   = 32;
	localparam int BYTE_W   = 8;
	localparam int PAIR_W   = 2;
	localparam int NIB_W    = 4;
	localparam int MUL_W    = 16;
	localparam int SEL_W    = 2;
	localparam int MSB_POS  = 31;
	localparam int SEL3_POS = 6;
	localparam int SEL2_POS = 4;
	localparam int SEL1_POS = 2;
	localparam int SEL0_POS = 0;

	localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
	localparam logic              CARRY_RST  = 1'b0;
	localparam logic              ZERO_RST   = 1'b0;

	typedef enum logic [7:0] {
		OP_COPY        = 8'h01,
		OP_BYTE_SHUF   = 8'h02,
		OP_UMUL        = 8'h04,
		OP_SMUL        = 8'h08,
		OP_CARRY_MUX   = 8'h10,
		OP_INV_CARRY   = 8'h20,
		OP_PAIR_COPY   = 8'h40,
		OP_NIBBLE_COPY = 8'h80
	} mma_op_t;

endpackage
